// ---- src/fram_link_pkg.sv ----
// shared constants and types for the two-wire memory slave port
package fram_link_pkg;
    localparam int ADDR_W = 9;
    localparam int BYTE_W = 8;
    // bit positions inside the slave address byte
    localparam int TYPE_HI = 7;
    localparam int TYPE_LO = 4;
    localparam int SEL_HI = 3;
    localparam int SEL_LO = 2;
    localparam int PAGE_BIT = 1;
    localparam int RW_BIT = 0;
    localparam logic RW_READ = 1'b1;
    localparam logic ACK_LEVEL = 1'b0;
    // bit counter values within one nine-clock byte frame
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam logic [3:0] CNT_STEP = 4'h1;
    localparam logic [3:0] CNT_LAST_BIT = 4'h7;
    localparam logic [3:0] CNT_ACK_SLOT = 4'h8;
    // reset values and the address step
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [8:0] ADDR_STEP = 9'h001;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [7:0] BYTE_IDLE = 8'hff;
    typedef enum logic [2:0] {
        LINK_IDLE, LINK_ADDR, LINK_WORD, LINK_WDATA, LINK_RDATA
    } link_state_type;
    typedef enum logic [2:0] {
        MEM_IDLE, MEM_WR, MEM_RD0, MEM_RD1, MEM_GET1
    } mem_state_type;
    // one request from the link to the memory side
    typedef struct packed {
        logic we;
        logic [8:0] waddr;
        logic [7:0] wdata;
        logic [7:0] fetch;
    } mem_req_type;
    // prefetched bytes at one low address, one per page
    typedef struct packed {
        logic [7:0] page1;
        logic [7:0] page0;
    } byte_pair_type;
    localparam mem_req_type REQ_RST = '0;
    localparam byte_pair_type PAIR_RST = '0;
endpackage

// ---- src/bit_sync.sv ----
// two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ---- src/bus_condition_detect.sv ----
// start and stop detectors clocked by the data line edges
`timescale 1ns/1ps
`default_nettype none
module bus_condition_detect (
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic start_tgl_out,
    output logic stop_tgl_out
);
    // data falling while clock high flips the start toggle
    always_ff @(negedge sda_in or posedge rst_in) begin
        if (rst_in) begin
            start_tgl_out <= 1'b0;
        end else if (scl_in) begin
            start_tgl_out <= ~start_tgl_out;
        end
    end

    // data rising while clock high flips the stop toggle
    always_ff @(posedge sda_in or posedge rst_in) begin
        if (rst_in) begin
            stop_tgl_out <= 1'b0;
        end else if (scl_in) begin
            stop_tgl_out <= ~stop_tgl_out;
        end
    end
endmodule
`default_nettype wire

// ---- src/serial_fram_i2c_slave_port.sv ----
// two-wire slave port of a 512-byte memory: link side on scl, memory port on ref_clk
`timescale 1ns/1ps
`default_nettype none
module serial_fram_i2c_slave_port
    import fram_link_pkg::*;
#(
    parameter logic [3:0] DEVICE_TYPE = 4'h5 // arbitrary type code value
) (
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_out,
    output logic sda_oe_n_out,
    input wire logic [1:0] device_select_pins_in,
    input wire logic write_protect_in,
    output logic [8:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    output logic mem_we_out,
    output logic mem_re_out,
    input wire logic [7:0] mem_rdata_in
);

    // link domain state
    link_state_type state_q;
    link_state_type next_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic ack_q;
    logic [8:0] latch_q;
    logic start_seen_q;
    logic stop_seen_q;
    logic oe_n_q;
    logic low_q;
    mem_req_type req_q;
    logic req_tgl_q;

    // memory domain state
    mem_state_type mem_state_q;
    mem_req_type cmd_q;
    logic req_prev_q;
    byte_pair_type pair_q;
    logic [8:0] mem_addr_q;
    logic [7:0] mem_wdata_q;
    logic mem_we_q;
    logic mem_re_q;

    // crossing and decode wires
    logic start_tgl;
    logic stop_tgl;
    logic [2:0] pin_sync;
    logic req_sync;
    logic req_edge;
    logic start_pend;
    logic stop_pend;
    logic run;
    logic last_bit;
    logic ack_slot;
    logic byte_end;
    logic slot_end;
    logic [7:0] rx_byte;
    logic addr_hit;
    logic rd_req;
    logic wp_on;
    logic master_ack;
    logic [8:0] latch_inc;
    logic ack_d;
    link_state_type next_d;
    logic [7:0] tx_byte;
    logic rd_first;
    logic rd_shift;

    // start and stop seen on the data line edges
    bus_condition_detect u_cond (
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .start_tgl_out(start_tgl),
        .stop_tgl_out(stop_tgl)
    );

    // select pins and write protect brought onto the link clock
    bit_sync #(.WIDTH(3)) u_pin_sync (
        .clk_in(scl_in),
        .rst_in(rst_in),
        .async_in({write_protect_in, device_select_pins_in}),
        .sync_out(pin_sync)
    );

    // request toggle brought onto the reference clock
    bit_sync #(.WIDTH(1)) u_req_sync (
        .clk_in(ref_clk_in),
        .rst_in(rst_in),
        .async_in(req_tgl_q),
        .sync_out(req_sync)
    );

    // pending conditions; protocol hold times keep these toggles settled at the scl edge
    assign start_pend = start_tgl != start_seen_q;
    assign stop_pend = stop_tgl != stop_seen_q;
    assign run = !start_pend && !stop_pend && (state_q != LINK_IDLE);

    // bit position decode within the byte frame
    assign last_bit = cnt_q == CNT_LAST_BIT;
    assign ack_slot = cnt_q == CNT_ACK_SLOT;
    assign byte_end = run && last_bit;
    assign slot_end = run && ack_slot;

    // incoming byte including the bit on the line now
    assign rx_byte = {rx_q[6:0], sda_in};

    // slave address match
    assign addr_hit = (rx_byte[TYPE_HI:TYPE_LO] == DEVICE_TYPE)
        && (rx_byte[SEL_HI:SEL_LO] == pin_sync[1:0]);
    assign rd_req = rx_byte[RW_BIT] == RW_READ;
    assign wp_on = pin_sync[2];
    assign master_ack = sda_in == ACK_LEVEL;
    assign latch_inc = latch_q + ADDR_STEP;

    // acknowledge decision taken at the eighth bit
    assign ack_d = (state_q == LINK_ADDR) ? addr_hit :
        (state_q == LINK_WORD) ? 1'b1 :
        (state_q == LINK_WDATA) ? !wp_on :
        1'b0;

    // state to enter after the acknowledge slot
    assign next_d = (state_q == LINK_ADDR) ?
            (!addr_hit ? LINK_IDLE : (rd_req ? LINK_RDATA : LINK_WORD)) :
        (state_q == LINK_WORD) ? LINK_WDATA :
        (state_q == LINK_WDATA) ? (wp_on ? LINK_IDLE : LINK_WDATA) :
        LINK_IDLE;

    // byte for the current address, chosen by the page bit
    assign tx_byte = latch_q[8] ? pair_q.page1 : pair_q.page0;
    assign rd_first = (state_q == LINK_RDATA) && (cnt_q == CNT_RST);
    assign rd_shift = (state_q == LINK_RDATA) && !ack_slot;

    // bit counter and protocol state, advanced on rising scl
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= LINK_IDLE;
            cnt_q <= CNT_RST;
        end else if (start_pend) begin
            state_q <= LINK_ADDR;
            cnt_q <= CNT_FIRST;
        end else if (stop_pend) begin
            state_q <= LINK_IDLE;
            cnt_q <= CNT_RST;
        end else if (slot_end && state_q == LINK_RDATA) begin
            state_q <= master_ack ? LINK_RDATA : LINK_IDLE;
            cnt_q <= CNT_RST;
        end else if (slot_end) begin
            state_q <= next_q;
            cnt_q <= CNT_RST;
        end else if (run) begin
            cnt_q <= cnt_q + CNT_STEP;
        end
    end

    // consume start and stop toggles at each rising scl
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
        end else begin
            start_seen_q <= start_tgl;
            stop_seen_q <= stop_tgl;
        end
    end

    // receive shift register samples data on rising scl
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            rx_q <= BYTE_RST;
        end else if (start_pend || (run && !ack_slot)) begin
            rx_q <= rx_byte;
        end
    end

    // acknowledge decision and follow-on state latched at the eighth bit
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            ack_q <= 1'b0;
            next_q <= LINK_IDLE;
        end else if (byte_end) begin
            ack_q <= ack_d;
            next_q <= next_d;
        end
    end

    // address latch: page from address byte, low bits from word byte
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            latch_q <= ADDR_RST;
        end else if (byte_end && state_q == LINK_ADDR && addr_hit) begin
            latch_q <= {rx_byte[PAGE_BIT], latch_q[7:0]};
        end else if (byte_end && state_q == LINK_WORD) begin
            latch_q <= {latch_q[8], rx_byte};
        end else if (byte_end && state_q == LINK_WDATA && !wp_on) begin
            latch_q <= latch_inc;
        end else if (byte_end && state_q == LINK_RDATA) begin
            latch_q <= latch_inc;
        end
    end

    // memory requests: toggle plus a payload held stable until the next one
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            req_q <= REQ_RST;
            req_tgl_q <= 1'b0;
        end else if (start_pend) begin
            // refresh both page bytes at the latched low address
            req_q <= '{we: 1'b0, waddr: latch_q, wdata: BYTE_RST, fetch: latch_q[7:0]};
            req_tgl_q <= ~req_tgl_q;
        end else if (byte_end && state_q == LINK_WORD) begin
            req_q <= '{we: 1'b0, waddr: latch_q, wdata: BYTE_RST, fetch: rx_byte};
            req_tgl_q <= ~req_tgl_q;
        end else if (byte_end && state_q == LINK_WDATA && !wp_on) begin
            // commit now, before the acknowledge slot
            req_q <= '{we: 1'b1, waddr: latch_q, wdata: rx_byte, fetch: latch_inc[7:0]};
            req_tgl_q <= ~req_tgl_q;
        end else if (run && rd_first) begin
            // prefetch the byte after the one now on the line
            req_q <= '{we: 1'b0, waddr: latch_q, wdata: BYTE_RST, fetch: latch_inc[7:0]};
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // data line driver, changed only on falling scl
    always_ff @(negedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            oe_n_q <= 1'b1;
            tx_q <= BYTE_IDLE;
        end else if (start_pend || stop_pend || state_q == LINK_IDLE) begin
            oe_n_q <= 1'b1;
            tx_q <= BYTE_IDLE;
        end else if (rd_first) begin
            oe_n_q <= tx_byte[7];
            tx_q <= {tx_byte[6:0], 1'b1};
        end else if (rd_shift) begin
            oe_n_q <= tx_q[7];
            tx_q <= {tx_q[6:0], 1'b1};
        end else if (ack_slot && state_q != LINK_RDATA) begin
            oe_n_q <= ~ack_q;
        end else begin
            oe_n_q <= 1'b1;
        end
    end

    // the pin is only ever pulled low; scl has no driver at all
    always_ff @(negedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            low_q <= 1'b0;
        end else begin
            low_q <= 1'b0;
        end
    end

    // edge of the synchronised request toggle
    assign req_edge = req_sync != req_prev_q;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            req_prev_q <= 1'b0;
        end else begin
            req_prev_q <= req_sync;
        end
    end

    // memory sequencer: optional write, then reads of both pages
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_state_q <= MEM_IDLE;
            cmd_q <= REQ_RST;
        end else begin
            unique case (mem_state_q)
                MEM_IDLE: begin
                    if (req_edge) begin
                        cmd_q <= req_q;
                        mem_state_q <= req_q.we ? MEM_WR : MEM_RD0;
                    end
                end
                MEM_WR: mem_state_q <= MEM_RD0;
                MEM_RD0: mem_state_q <= MEM_RD1;
                MEM_RD1: mem_state_q <= MEM_GET1;
                MEM_GET1: mem_state_q <= MEM_IDLE;
            endcase
        end
    end

    // memory port strobes and address, all registered
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mem_addr_q <= ADDR_RST;
            mem_wdata_q <= BYTE_RST;
            mem_we_q <= 1'b0;
            mem_re_q <= 1'b0;
        end else if (mem_state_q == MEM_IDLE && req_edge && req_q.we) begin
            mem_addr_q <= req_q.waddr;
            mem_wdata_q <= req_q.wdata;
            mem_we_q <= 1'b1;
            mem_re_q <= 1'b0;
        end else if (mem_state_q == MEM_IDLE && req_edge) begin
            mem_addr_q <= {1'b0, req_q.fetch};
            mem_we_q <= 1'b0;
            mem_re_q <= 1'b1;
        end else if (mem_state_q == MEM_WR) begin
            mem_addr_q <= {1'b0, cmd_q.fetch};
            mem_we_q <= 1'b0;
            mem_re_q <= 1'b1;
        end else if (mem_state_q == MEM_RD0) begin
            mem_addr_q <= {1'b1, cmd_q.fetch};
        end else begin
            mem_we_q <= 1'b0;
            mem_re_q <= 1'b0;
        end
    end

    // read data arrives the cycle after each read strobe
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pair_q <= PAIR_RST;
        end else if (mem_state_q == MEM_RD1) begin
            pair_q.page0 <= mem_rdata_in;
        end else if (mem_state_q == MEM_GET1) begin
            pair_q.page1 <= mem_rdata_in;
        end
    end

    // outputs straight from flip-flops
    assign sda_out_out = low_q;
    assign sda_oe_n_out = oe_n_q;
    assign mem_addr_out = mem_addr_q;
    assign mem_wdata_out = mem_wdata_q;
    assign mem_we_out = mem_we_q;
    assign mem_re_out = mem_re_q;

endmodule
`default_nettype wire

// ---- bench/fram_port_sva.sv ----
// concurrent checks on the ports of the two-wire memory slave port
`timescale 1ns/1ps
`default_nettype none
module fram_port_sva
    import fram_link_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out_out,
    input wire logic sda_oe_n_out,
    input wire logic [1:0] device_select_pins_in,
    input wire logic write_protect_in,
    input wire logic [8:0] mem_addr_out,
    input wire logic [7:0] mem_wdata_out,
    input wire logic mem_we_out,
    input wire logic mem_re_out,
    input wire logic [7:0] mem_rdata_in
);
    logic [7:0] wp_cnt_q;
    logic [3:0] scl_hi_q;
    // saturating counts of ref cycles with write protect high and bus clock high
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_cnt_q <= 8'h00;
            scl_hi_q <= 4'h0;
        end else begin
            wp_cnt_q <= !write_protect_in ? 8'h00 : (&wp_cnt_q ? wp_cnt_q : wp_cnt_q + 8'h01);
            scl_hi_q <= !scl_in ? 4'h0 : (&scl_hi_q ? scl_hi_q : scl_hi_q + 4'h1);
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    // one fetch: low page strobe, then high page strobe, then quiet
    sequence fetch_pair_seq;
        (mem_re_out && !mem_addr_out[8]) ##1 (mem_re_out && mem_addr_out[8]) ##1 !mem_re_out;
    endsequence
    a_drive_low_only: assert property (sda_out_out == ACK_LEVEL)
        else $error("data drive value is not low");
    a_oe_on_low_clock: assert property ($changed(sda_oe_n_out) |-> !scl_in)
        else $error("data enable moved while bus clock high");
    a_write_one_cycle: assert property (mem_we_out |=> !mem_we_out)
        else $error("write strobe longer than one cycle");
    a_write_then_fetch: assert property (mem_we_out |=> fetch_pair_seq)
        else $error("write not followed by page pair fetch");
    a_fetch_page_pair: assert property ($rose(mem_re_out) |-> fetch_pair_seq)
        else $error("fetch is not a low then high page pair");
    a_fetch_next_low: assert property (mem_we_out |=>
        mem_addr_out[7:0] == $past(mem_addr_out[7:0]) + 8'h01)
        else $error("fetch after write not at next address");
    a_wp_blocks_write: assert property (wp_cnt_q > 8'hc8 |-> !mem_we_out)
        else $error("memory written while protected");
    a_idle_released: assert property (scl_hi_q > 4'h9 |-> sda_oe_n_out)
        else $error("data line held low while bus idle");
endmodule
bind serial_fram_i2c_slave_port fram_port_sva u_sva (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out_out(sda_out_out),
    .sda_oe_n_out(sda_oe_n_out), .device_select_pins_in(device_select_pins_in),
    .write_protect_in(write_protect_in), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out), .mem_re_out(mem_re_out),
    .mem_rdata_in(mem_rdata_in));
`default_nettype wire

// ---- bench/two_wire_master.sv ----
// behavioural bus master: makes the bus clock only within frames, releases data to pull-up
`timescale 1ns/1ps
`default_nettype none
module two_wire_master (
    input wire logic sda_in,
    output var logic scl_out,
    output var logic sda_drv_out
);
    localparam int QTR = 12; // quarter of the 48 ns bus period
    // clock stands high and data released while idle
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    // data changes only while the clock is low
    task automatic put_bit(input logic b);
        sda_drv_out = b;
        #QTR scl_out = 1'b1;
        #(2*QTR) scl_out = 1'b0;
        #QTR;
    endtask
    // release data and sample it mid high phase
    task automatic get_bit(output logic b);
        sda_drv_out = 1'b1;
        #QTR scl_out = 1'b1;
        #QTR b = sda_in;
        #QTR scl_out = 1'b0;
        #QTR;
    endtask
    task automatic start_cond();
        sda_drv_out = 1'b1;
        #QTR scl_out = 1'b1;
        #QTR sda_drv_out = 1'b0;
        #QTR scl_out = 1'b0;
        #QTR;
    endtask
    task automatic stop_cond();
        sda_drv_out = 1'b0;
        #QTR scl_out = 1'b1;
        #QTR sda_drv_out = 1'b1;
        #(2*QTR);
    endtask
    // byte out high bit first, then the target's answer
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask
    // byte in; last wanted byte is left unacknowledged
    task automatic recv_byte(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) get_bit(d[i]);
        put_bit(!more);
    endtask
endmodule
`default_nettype wire

// ---- bench/serial_fram_i2c_slave_port_test.sv ----
// self-checking bench for the two-wire memory slave port
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("wrong value %s expected %h seen %h", what, exp, got); end end
module serial_fram_i2c_slave_port_test;
    import fram_link_pkg::*;
    localparam logic [3:0] TYPE_CODE = 4'h9; // arbitrary type code
    localparam logic [1:0] SEL = 2'h2;
    logic ref_clk_in;
    logic rst_in;
    logic scl;
    logic sda_drv;
    wire logic sda_bus;
    logic sda_low;
    logic sda_oe_n;
    logic [1:0] pins;
    logic wp;
    logic [8:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic [7:0] rdata;
    logic [7:0] mem [512];
    logic [7:0] exp_mem [512];
    logic ack;
    logic [7:0] d;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // wired-and bus with pull-up
    assign sda_bus = sda_drv & (sda_oe_n | sda_low);
    serial_fram_i2c_slave_port #(.DEVICE_TYPE(TYPE_CODE)) u_dut (.ref_clk_in(ref_clk_in),
        .rst_in(rst_in), .scl_in(scl), .sda_in(sda_bus), .sda_out_out(sda_low),
        .sda_oe_n_out(sda_oe_n), .device_select_pins_in(pins), .write_protect_in(wp),
        .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_we_out(mem_we),
        .mem_re_out(mem_re), .mem_rdata_in(rdata));
    two_wire_master u_master (.sda_in(sda_bus), .scl_out(scl), .sda_drv_out(sda_drv));
    initial begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end
    // memory array; read data valid the cycle after its strobe
    always @(posedge ref_clk_in) begin
        if (mem_we) mem[mem_addr] <= mem_wdata;
        if (mem_re) rdata <= mem[mem_addr];
        cycles++;
        if (cycles == 5000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] slave_addr(logic [3:0] t, logic [1:0] s, logic pg, logic rd);
        return {t, s, pg, rd};
    endfunction
    task automatic set_pins(input logic [1:0] p, input logic w);
        @(negedge ref_clk_in);
        pins = p;
        wp = w;
    endtask
    // address, word address and n data bytes; no stop
    task automatic do_write(input logic pg, input logic [7:0] word, input int n, input logic [7:0] v);
        logic [8:0] a;
        a = {pg, word};
        u_master.start_cond();
        u_master.send_byte(slave_addr(TYPE_CODE, SEL, pg, 1'b0), ack);
        `CHK("address ack", 1'b1, ack)
        u_master.send_byte(word, ack);
        `CHK("word ack", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            u_master.send_byte(v + 8'(i), ack);
            `CHK("data ack", !wp, ack)
            if (!wp) exp_mem[a] = v + 8'(i);
            if (!wp) a = a + 9'h001;
        end
    endtask
    // current address read of n bytes from low address lo, then stop
    task automatic do_read(input logic pg, input logic [7:0] lo, input int n);
        logic [8:0] a;
        a = {pg, lo};
        u_master.start_cond();
        u_master.send_byte(slave_addr(TYPE_CODE, SEL, pg, 1'b1), ack);
        `CHK("read address ack", 1'b1, ack)
        for (int i = 0; i < n; i++) begin
            u_master.recv_byte(i < n - 1, d);
            `CHK("read byte", exp_mem[a], d)
            // the nine-bit latch carries into the page bit and wraps to zero
            a = a + 9'h001;
        end
        u_master.stop_cond();
    endtask
    task automatic check_array(input logic [8:0] a, input int n);
        repeat (10) @(negedge ref_clk_in);
        for (int k = 0; k < n; k++) `CHK("array", exp_mem[a + 9'(k)], mem[a + 9'(k)])
    endtask
    // wrong type, wrong select, then a matching select on other pins
    task automatic test_mismatch();
        for (int k = 0; k < 3; k++) begin
            set_pins(k == 2 ? 2'h1 : SEL, 1'b0);
            u_master.start_cond();
            u_master.send_byte(slave_addr(k == 0 ? ~TYPE_CODE : TYPE_CODE,
                k == 0 ? SEL : 2'h1, 1'b0, 1'b0), ack);
            `CHK("select ack", k == 2, ack)
            u_master.send_byte(8'h40, ack);
            `CHK("byte after select", k == 2, ack)
            u_master.stop_cond();
        end
        set_pins(SEL, 1'b0);
    endtask
    // sequential write across the top location, then read from next address
    task automatic test_wrap();
        do_write(1'b1, 8'hfe, 3, 8'h3c);
        u_master.stop_cond();
        check_array(9'h1fe, 3);
        do_read(1'b0, 8'h01, 2);
    endtask
    // word address then repeated start into a read
    task automatic test_select();
        do_write(1'b1, 8'hff, 0, 8'h00);
        do_read(1'b1, 8'hff, 2);
    endtask
    task automatic test_wp();
        set_pins(SEL, 1'b1);
        repeat (210) @(negedge ref_clk_in);
        do_write(1'b0, 8'h20, 2, 8'h77);
        u_master.stop_cond();
        check_array(9'h020, 2);
        set_pins(SEL, 1'b0);
        do_read(1'b0, 8'h20, 1);
    endtask
    // partial data byte cut by stop, then by start
    task automatic test_abort();
        do_write(1'b0, 8'h30, 0, 8'h00);
        for (int i = 0; i < 5; i++) u_master.put_bit(i[0]);
        u_master.stop_cond();
        check_array(9'h030, 1);
        do_read(1'b0, 8'h30, 1);
        do_write(1'b0, 8'h31, 0, 8'h00);
        for (int i = 0; i < 4; i++) u_master.put_bit(1'b0);
        do_read(1'b0, 8'h31, 1);
        check_array(9'h031, 1);
    endtask
    initial begin
        rst_in = 1'b1;
        pins = SEL;
        wp = 1'b0;
        rdata = 8'h00;
        for (int k = 0; k < 512; k++) mem[k] = 8'(k * 5 + 1);
        for (int k = 0; k < 512; k++) exp_mem[k] = mem[k];
        repeat (2) @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge ref_clk_in);
        test_mismatch();
        test_wrap();
        test_select();
        test_wp();
        test_abort();
        wrap_up();
    end
endmodule
`default_nettype wire
